// ===== power_state_ctrl.sv
// Contract
// - sleep halts CPU, oscillators and peripherals run
// - medium sleep clocks peripherals by divider field
// - CPU register state held during sleep
// - interrupt ends sleep, starts exception handling
// - mask bit or disabled source keeps sleep
// - wake returns to matching active speed
// - reset pin low resets CPU, ends sleep
// - request to exception within two cycles
// - standby keeps ports, outputs high impedance
// - standby watchdog runs only on on-chip oscillator
// - watch/sub modes watchdog on osc or divided clock
// - watch/sub modes clock needs 32k source
`timescale 1ns/1ps
module power_state_ctrl
    import power_state_pkg::*;
#(
    parameter int N_IRQ = 4
) (
    // clock and reset
    input wire logic             clk,
    input wire logic             reset,
    // register port
    input wire logic [7:0]       reg_addr,
    input wire logic [31:0]      reg_wdata,
    input wire logic             reg_write,
    input wire logic             reg_read,
    output logic [31:0]          reg_rdata,
    // cpu core side
    input wire logic             sleep_exec,
    input wire logic             cpu_condition_code_mask,
    input wire logic [N_IRQ-1:0] irq_request,
    input wire logic [N_IRQ-1:0] irq_enable,
    output logic                 cpu_halt,
    output logic                 cpu_reset,
    output logic                 exception_start,
    // pins
    input wire logic             external_reset_pin_n,
    output logic                 port_hiz,
    // clock and peripheral gating
    output logic                 sys_osc_run,
    output logic                 sub_osc_run,
    output logic                 periph_tick,
    output logic                 watchdog_unit_run,
    output logic                 rtc_run,
    output logic                 always_on_run,
    output logic                 async_serial_unit_reset,
    output logic                 two_wire_serial_unit_run,
    output logic [7:0]           mode_state
);
    // software registers
    logic [7:0] system_control_one;  // mode select and divider field
    logic [7:0] system_control_two;  // speed and direct transition
    logic [7:0] clock_src;           // watchdog and clock sources
    mode_type   mode;                // current operating mode
    mode_type   next_mode;
    logic       next_exception;

    // reset pin synchroniser, first stage read only by second
    logic pin_meta;
    logic pin_sync;

    // field decode
    wire logic       standby_sel = system_control_one[BIT_STANDBY_SEL];
    wire logic       low_speed   = system_control_one[BIT_LOW_SPEED_ON];
    wire logic       watch_sel   = system_control_one[BIT_WATCH_SEL];
    wire logic [1:0] med_div_sel = {
        system_control_one[BIT_MED_DIV_HI],
        system_control_one[BIT_MED_DIV_LO]};
    wire logic       med_speed   = system_control_two[BIT_MED_SPEED_ON];
    wire logic       direct_on   = system_control_two[BIT_DIRECT_ON];
    wire logic       wdt_on_chip = clock_src[BIT_WDT_ON_CHIP];
    wire logic [1:0] wdt_wdiv    = {
        clock_src[BIT_WDT_WDIV_HI], clock_src[BIT_WDT_WDIV_LO]};
    wire logic       rtc_32k     = clock_src[BIT_RTC_32K];

    // register address decode
    wire logic sel_one    = reg_addr == OFS_CONTROL_ONE;
    wire logic sel_two    = reg_addr == OFS_CONTROL_TWO;
    wire logic sel_src    = reg_addr == OFS_CLOCK_SRC;
    wire logic sel_status = reg_addr == OFS_MODE_STATUS;
    wire logic [7:0] read_mux = sel_one    ? system_control_one :
                                sel_two    ? system_control_two :
                                sel_src    ? clock_src :
                                sel_status ? 8'(mode) : 8'h00;

    // mode group decode
    wire logic in_active   = mode == MODE_ACTIVE_HS
                           || mode == MODE_ACTIVE_MS;
    wire logic in_sleep    = mode == MODE_SLEEP_HS
                           || mode == MODE_SLEEP_MS;
    wire logic in_sub_lp   = mode == MODE_WATCH
                           || mode == MODE_SUBACTIVE
                           || mode == MODE_SUBSLEEP;
    wire logic in_standby  = mode == MODE_STANDBY;
    wire logic in_medium   = mode == MODE_ACTIVE_MS
                           || mode == MODE_SLEEP_MS;
    wire logic cpu_running = in_active || mode == MODE_SUBACTIVE;

    // active target chosen by the speed bit
    wire mode_type active_target =
        med_speed ? MODE_ACTIVE_MS : MODE_ACTIVE_HS;
    wire mode_type sleep_target  =
        med_speed ? MODE_SLEEP_MS : MODE_SLEEP_HS;

    // interrupt wake path through the detector
    wake_bus_if #(.N(N_IRQ)) wake_bus ();
    assign wake_bus.request = irq_request;
    assign wake_bus.enable  = irq_enable;

    irq_wake_detect #(.N(N_IRQ)) u_wake (
        .clk   (clk),
        .reset (reset),
        .bus   (wake_bus)
    );

    // live request too: a source disabled after the detector
    // latched it must not end a halt one cycle later
    wire logic req_live = |(irq_request & irq_enable);
    // mask bit set keeps the device halted
    wire logic wake_ok = wake_bus.wake && req_live
                      && !cpu_condition_code_mask;

    // medium-speed peripheral divider
    logic med_tick;
    medspeed_divider u_div (
        .clk   (clk),
        .reset (reset),
        .sel   (med_div_sel),
        .tick  (med_tick)
    );

    // watchdog clock permission in watch and sub modes
    wire logic wdt_wclk_ok = wdt_on_chip
                           || wdt_wdiv == WDIV_16
                           || wdt_wdiv == WDIV_256;

    // next mode on a sleep instruction or a wake event
    always_comb begin
        next_mode      = mode;
        next_exception = 1'b0;
        case (mode)
            // halt entry from the running modes
            MODE_ACTIVE_HS, MODE_ACTIVE_MS: begin
                if (sleep_exec) begin
                    if (!standby_sel) begin
                        if (direct_on) begin
                            next_mode      = active_target;
                            next_exception = !cpu_condition_code_mask;
                        end else begin
                            next_mode = sleep_target;
                        end
                    end else if (!watch_sel) begin
                        next_mode = MODE_STANDBY;
                    end else if (direct_on) begin
                        next_mode      = low_speed ? MODE_SUBACTIVE
                                                   : active_target;
                        next_exception = !cpu_condition_code_mask;
                    end else begin
                        next_mode = MODE_WATCH;
                    end
                end
            end
            MODE_SUBACTIVE: begin
                if (sleep_exec) begin
                    if (!standby_sel && low_speed && watch_sel) begin
                        next_mode = MODE_SUBSLEEP;
                    end else if (standby_sel && watch_sel) begin
                        if (direct_on) begin
                            next_mode      = low_speed ? MODE_SUBACTIVE
                                                       : active_target;
                            next_exception = !cpu_condition_code_mask;
                        end else begin
                            next_mode = MODE_WATCH;
                        end
                    end
                end
            end
            // halted modes leave on an accepted interrupt
            MODE_SLEEP_HS: begin
                if (wake_ok) begin
                    next_mode      = MODE_ACTIVE_HS;
                    next_exception = 1'b1;
                end
            end
            MODE_SLEEP_MS: begin
                if (wake_ok) begin
                    next_mode      = MODE_ACTIVE_MS;
                    next_exception = 1'b1;
                end
            end
            MODE_STANDBY: begin
                if (wake_ok) begin
                    next_mode      = active_target;
                    next_exception = 1'b1;
                end
            end
            MODE_WATCH: begin
                if (wake_ok) begin
                    next_mode      = low_speed ? MODE_SUBACTIVE
                                               : active_target;
                    next_exception = 1'b1;
                end
            end
            MODE_SUBSLEEP: begin
                if (wake_ok) begin
                    next_mode      = MODE_SUBACTIVE;
                    next_exception = 1'b1;
                end
            end
            default: begin
                next_mode = MODE_ACTIVE_HS;
            end
        endcase
    end

    // reset pin synchroniser
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pin_meta <= 1'b1;
            pin_sync <= 1'b1;
        end else begin
            pin_meta <= external_reset_pin_n;
            pin_sync <= pin_meta;
        end
    end

    // software registers and read port
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            system_control_one <= RST_CONTROL_ONE;
            system_control_two <= RST_CONTROL_TWO;
            clock_src          <= RST_CLOCK_SRC;
            reg_rdata          <= 32'h0000_0000;
        end else begin
            if (reg_write && sel_one) begin
                system_control_one <= reg_wdata[7:0];
            end
            if (reg_write && sel_two) begin
                system_control_two <= reg_wdata[7:0];
            end
            if (reg_write && sel_src) begin
                clock_src <= reg_wdata[7:0];
            end
            // unmapped offsets read as zero
            reg_rdata <= reg_reads_zero(reg_read) ? 32'h0000_0000
                                                 : {24'h000000, read_mux};
        end
    end

    function automatic logic reg_reads_zero(input logic rd);
        reg_reads_zero = !rd;
    endfunction

    // mode state; a low reset pin overrides every transition
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            mode            <= MODE_ACTIVE_HS;
            exception_start <= 1'b0;
            cpu_reset       <= 1'b1;
        end else if (!pin_sync) begin
            mode            <= MODE_ACTIVE_HS;
            exception_start <= 1'b0;
            cpu_reset       <= 1'b1;
        end else begin
            mode            <= next_mode;
            exception_start <= next_exception;
            cpu_reset       <= 1'b0;
        end
    end

    // registered gating outputs, one cycle behind the mode
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cpu_halt                 <= 1'b0;
            port_hiz                 <= 1'b0;
            sys_osc_run              <= 1'b1;
            sub_osc_run              <= 1'b1;
            periph_tick              <= 1'b0;
            watchdog_unit_run        <= 1'b1;
            rtc_run                  <= 1'b1;
            always_on_run            <= 1'b1;
            async_serial_unit_reset  <= 1'b0;
            two_wire_serial_unit_run <= 1'b1;
            mode_state               <= 8'h01;
        end else begin
            // halt freezes the core, so its registers keep their value
            cpu_halt    <= !cpu_running;
            port_hiz    <= in_standby;
            sys_osc_run <= in_active || in_sleep;
            // subclock left running in every mode
            sub_osc_run <= 1'b1;
            // peripherals stop only in watch and standby
            periph_tick <= (in_medium ? med_tick : 1'b1)
                           && !in_standby && mode != MODE_WATCH;
            watchdog_unit_run <= in_standby ? wdt_on_chip
                               : in_sub_lp  ? wdt_wclk_ok
                               : 1'b1;
            rtc_run <= in_standby ? 1'b0
                     : in_sub_lp  ? rtc_32k
                     : 1'b1;
            always_on_run <= 1'b1;
            async_serial_unit_reset <= in_standby
                                    || mode == MODE_WATCH;
            two_wire_serial_unit_run <= in_active || in_sleep;
            mode_state <= 8'(mode);
        end
    end
endmodule

// ===== power_state_pkg.sv
package power_state_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_CONTROL_ONE = 8'h00;
    localparam logic [7:0] OFS_CONTROL_TWO = 8'h04;
    localparam logic [7:0] OFS_CLOCK_SRC   = 8'h08;
    localparam logic [7:0] OFS_MODE_STATUS = 8'h0C;
    // system_control_one fields
    localparam int BIT_STANDBY_SEL   = 0;
    localparam int BIT_LOW_SPEED_ON  = 1;
    localparam int BIT_WATCH_SEL     = 2;
    localparam int BIT_MED_DIV_LO    = 4;
    localparam int BIT_MED_DIV_HI    = 5;
    // system_control_two fields
    localparam int BIT_MED_SPEED_ON  = 0;
    localparam int BIT_DIRECT_ON     = 1;
    // clock source fields
    localparam int BIT_WDT_ON_CHIP   = 0;
    localparam int BIT_WDT_WDIV_LO   = 1;
    localparam int BIT_WDT_WDIV_HI   = 2;
    localparam int BIT_RTC_32K       = 3;
    // watchdog watch-clock divider codes
    localparam logic [1:0] WDIV_OTHER = 2'h0;
    localparam logic [1:0] WDIV_16    = 2'h1;
    localparam logic [1:0] WDIV_256   = 2'h2;
    // reset values
    localparam logic [7:0] RST_CONTROL_ONE = 8'h00;
    localparam logic [7:0] RST_CONTROL_TWO = 8'h00;
    localparam logic [7:0] RST_CLOCK_SRC   = 8'h00;
    // medium-speed divider: log2 of the smallest ratio
    localparam int MED_DIV_BASE_LOG2 = 3;
    localparam int MED_DIV_CNT_W     = 6;
    // operating modes, one-hot
    typedef enum logic [7:0] {
        MODE_ACTIVE_HS = 8'h01,
        MODE_ACTIVE_MS = 8'h02,
        MODE_SLEEP_HS  = 8'h04,
        MODE_SLEEP_MS  = 8'h08,
        MODE_STANDBY   = 8'h10,
        MODE_WATCH     = 8'h20,
        MODE_SUBACTIVE = 8'h40,
        MODE_SUBSLEEP  = 8'h80
    } mode_type;
endpackage

// ===== wake_bus_if.sv
`timescale 1ns/1ps
interface wake_bus_if #(parameter int N = 4);
    logic [N-1:0] request;   // raw interrupt requests
    logic [N-1:0] enable;    // per-source enable bits
    logic         wake;      // registered enabled request
    modport ctrl (output request, output enable, input wake);
    modport detect (input request, input enable, output wake);
endinterface

// ===== irq_wake_detect.sv
`timescale 1ns/1ps
module irq_wake_detect
    import power_state_pkg::*;
#(
    parameter int N = 4
) (
    // clock and reset
    input wire logic  clk,
    input wire logic  reset,
    // request side
    wake_bus_if.detect bus
);
    // any enabled source; a disabled one never wakes
    wire logic any_enabled = |(bus.request & bus.enable);

    // one register stage keeps the wake path within two cycles
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            bus.wake <= 1'b0;
        end else begin
            bus.wake <= any_enabled;
        end
    end
endmodule

// ===== medspeed_divider.sv
`timescale 1ns/1ps
module medspeed_divider
    import power_state_pkg::*;
(
    // clock and reset
    input wire logic       clk,
    input wire logic       reset,
    // ratio select, ratio = 2^(sel+base)
    input wire logic [1:0] sel,
    // one-cycle peripheral tick
    output logic           tick
);
    logic [MED_DIV_CNT_W-1:0] count;   // free-running divider count
    wire logic [MED_DIV_CNT_W-1:0] mask;
    wire logic hit;

    // low bits that must be zero for the chosen ratio
    assign mask = MED_DIV_CNT_W'((1 << (int'(sel) + MED_DIV_BASE_LOG2)) - 1);
    assign hit  = (count & mask) == '0;

    // counter and tick register
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            count <= '0;
            tick  <= 1'b0;
        end else begin
            count <= count + MED_DIV_CNT_W'(1);
            tick  <= hit;
        end
    end
endmodule

// ===== cpu_core_model.sv
`timescale 1ns/1ps
module cpu_core_model #(
    parameter int N_IRQ = 4
) (
    // clock
    input wire logic         clk,
    // towards the controller
    output logic             sleep_exec,
    output logic             cpu_condition_code_mask,
    output logic [N_IRQ-1:0] irq_request,
    output logic [N_IRQ-1:0] irq_enable,
    // from the controller
    input wire logic         exception_start
);
    // quiet core: unmasked, no sources enabled
    initial begin
        sleep_exec = 1'b0;
        cpu_condition_code_mask = 1'b0;
        irq_request = '0;
        irq_enable = '0;
    end
    // halt request is a one-cycle pulse as the instruction retires
    task automatic run_sleep();
        @(posedge clk);
        sleep_exec <= 1'b1;
        @(posedge clk);
        sleep_exec <= 1'b0;
    endtask
    // mask, enables and raw requests as plain levels
    task automatic set_lines(input logic m, input logic [N_IRQ-1:0] en,
                             input logic [N_IRQ-1:0] req);
        @(posedge clk);
        cpu_condition_code_mask <= m;
        irq_enable <= en;
        irq_request <= req;
    endtask
    // request held until taken or until 20 cycles have passed, then dropped
    task automatic raise_irq(input int src, input int slow, output int lat);
        repeat (slow + 1) @(posedge clk);
        irq_request <= irq_request | (N_IRQ'(1) << src);
        lat = 0;
        do begin
            @(posedge clk);
            #1;
            lat++;
        end while (lat < 20 && exception_start !== 1'b1);
        @(posedge clk);
        irq_request <= '0;
    endtask
endmodule

// ===== power_state_monitor.sv
`timescale 1ns/1ps
module power_state_monitor
    import power_state_pkg::*;
#(
    parameter int N_IRQ = 4
) (
    // clock and reset
    input wire logic             clk,
    input wire logic             reset,
    // register writes
    input wire logic [7:0]       reg_addr,
    input wire logic [31:0]      reg_wdata,
    input wire logic             reg_write,
    // cpu side
    input wire logic             cpu_condition_code_mask,
    input wire logic [N_IRQ-1:0] irq_request,
    input wire logic [N_IRQ-1:0] irq_enable,
    input wire logic             cpu_halt,
    input wire logic             cpu_reset,
    input wire logic             exception_start,
    // pins and gating
    input wire logic             external_reset_pin_n,
    input wire logic             port_hiz,
    input wire logic             sys_osc_run,
    input wire logic             periph_tick,
    input wire logic             watchdog_unit_run,
    input wire logic             rtc_run,
    input wire logic             always_on_run,
    input wire logic             async_serial_unit_reset,
    input wire logic [7:0]       mode_state
);
    logic [7:0] clk_src;  // shadow of the clock source register
    logic       in_sleep; // either sleep speed
    logic       low_pwr;  // watch or sub modes
    logic       woke;     // some enabled request present
    assign in_sleep = mode_state == 8'h04 || mode_state == 8'h08;
    assign low_pwr = mode_state inside {8'h20, 8'h40, 8'h80};
    assign woke = |(irq_request & irq_enable);
    // shadow tracks software writes; only valid if writes avoid low power
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            clk_src <= 8'h00;
        end else if (reg_write && reg_addr == OFS_CLOCK_SRC) begin
            clk_src <= reg_wdata[7:0];
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    sleep_runs_a: assert property (
        in_sleep |-> cpu_halt && sys_osc_run)
        else $error("sleep with cpu running or oscillator off");
    // both cycles in medium sleep: a pin reset may end it on a tick
    med_tick_a: assert property (
        (mode_state == 8'h08 && periph_tick) ##1 mode_state == 8'h08
        |-> !periph_tick)
        else $error("medium sleep ticks undivided");
    hold_sleep_a: assert property (
        (mode_state == 8'h04 && (cpu_condition_code_mask || !woke)) [*3]
        |-> !exception_start)
        else $error("blocked request ended sleep");
    wake_fast_a: assert property (
        $rose(woke) && !cpu_condition_code_mask && mode_state == 8'h04
        |-> ##[1:2] exception_start)
        else $error("wake later than two cycles");
    wake_speed_a: assert property (
        exception_start && in_sleep
        |=> mode_state == ($past(mode_state) >> 2))
        else $error("wake to wrong speed");
    pin_reset_a: assert property (
        !external_reset_pin_n [*5] |-> cpu_reset && mode_state == 8'h01)
        else $error("pin low without cpu reset");
    standby_hiz_a: assert property (
        port_hiz == (mode_state == 8'h10))
        else $error("port drive wrong for mode");
    standby_wdt_a: assert property (
        mode_state == 8'h10 |-> watchdog_unit_run == clk_src[0])
        else $error("standby watchdog gating wrong");
    sub_wdt_a: assert property (
        low_pwr |-> watchdog_unit_run ==
        (clk_src[0] || clk_src[2:1] inside {2'h1, 2'h2}))
        else $error("low power watchdog gating wrong");
    rtc_src_a: assert property (
        low_pwr |-> rtc_run == clk_src[3])
        else $error("clock unit gating wrong");
    serial_reset_a: assert property (
        async_serial_unit_reset == (mode_state inside {8'h10, 8'h20}))
        else $error("serial reset wrong for mode");
    always_on_a: assert property (
        always_on_run)
        else $error("event counter stopped");
    osc_mode_a: assert property (
        sys_osc_run == (mode_state inside {8'h01, 8'h02, 8'h04, 8'h08}))
        else $error("oscillator state wrong for mode");
endmodule
bind power_state_ctrl power_state_monitor #(.N_IRQ(N_IRQ)) u_mon (
    .clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .cpu_condition_code_mask(cpu_condition_code_mask),
    .irq_request(irq_request), .irq_enable(irq_enable), .cpu_halt(cpu_halt),
    .cpu_reset(cpu_reset), .exception_start(exception_start),
    .external_reset_pin_n(external_reset_pin_n), .port_hiz(port_hiz),
    .sys_osc_run(sys_osc_run), .periph_tick(periph_tick),
    .watchdog_unit_run(watchdog_unit_run), .rtc_run(rtc_run),
    .always_on_run(always_on_run), .mode_state(mode_state),
    .async_serial_unit_reset(async_serial_unit_reset));

// ===== sleep_mode_power_state_control_tb.sv
`timescale 1ns/1ps
module sleep_mode_power_state_control_tb;
    import power_state_pkg::*;
    logic        clk, reset;          // clock and reset
    logic [7:0]  reg_addr;            // register port
    logic [31:0] reg_wdata, reg_rdata;
    logic        reg_write, reg_read;
    logic        sleep_exec, mask;    // core side
    logic [3:0]  irq_request, irq_enable;
    logic        cpu_halt, cpu_reset, exception_start;
    logic        pin_n, port_hiz;     // pins
    logic        sys_osc, sub_osc, tick, wdt_run, rtc_run;
    logic        aon_run, ser_rst, twi_run;
    logic [7:0]  mode_state;
    int          err_count, compares, lat, ticks;
    power_state_ctrl #(.N_IRQ(4)) u_dut (
        .clk(clk), .reset(reset), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .sleep_exec(sleep_exec),
        .cpu_condition_code_mask(mask), .irq_request(irq_request),
        .irq_enable(irq_enable), .cpu_halt(cpu_halt),
        .cpu_reset(cpu_reset), .exception_start(exception_start),
        .external_reset_pin_n(pin_n), .port_hiz(port_hiz),
        .sys_osc_run(sys_osc), .sub_osc_run(sub_osc), .periph_tick(tick),
        .watchdog_unit_run(wdt_run), .rtc_run(rtc_run),
        .always_on_run(aon_run), .async_serial_unit_reset(ser_rst),
        .two_wire_serial_unit_run(twi_run), .mode_state(mode_state));
    cpu_core_model #(.N_IRQ(4)) u_cpu (
        .clk(clk), .sleep_exec(sleep_exec), .cpu_condition_code_mask(mask),
        .irq_request(irq_request), .irq_enable(irq_enable),
        .exception_start(exception_start));
    // 50 MHz
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // one comparison, four-state exact
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %0t got %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic give_verdict();
        if (err_count == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // let n edges pass, then look once settled
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_write <= 1'b1;
        reg_addr <= a;
        reg_wdata <= {24'h0, d};
        @(posedge clk);
        reg_write <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_read <= 1'b0;
        #1 chk(reg_rdata, exp);
    endtask
    // sleep, then check the mode reached
    task automatic halt(input logic [7:0] exp);
        u_cpu.run_sleep();
        step(3);
        chk({24'h0, mode_state}, {24'h0, exp});
    endtask
    // wake by one source; a lost wake ends the run
    task automatic wake(input int src, input int slow, input logic [7:0] exp);
        u_cpu.raise_irq(src, slow, lat);
        if (lat >= 20) begin
            err_count++;
            give_verdict();
        end
        chk({31'h0, lat <= 2}, 32'h1);
        step(2);
        chk({24'h0, mode_state}, {24'h0, exp});
        chk({31'h0, cpu_halt}, 32'h0);
    endtask
    initial begin
        reset = 1'b1;
        reg_addr = 8'h00;
        reg_wdata = 32'h0;
        reg_write = 1'b0;
        reg_read = 1'b0;
        pin_n = 1'b1;
        err_count = 0;
        compares = 0;
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        // status, unmapped place and read-only status
        rd(OFS_MODE_STATUS, 32'h01);
        rd(8'h10, 32'h0);
        wr(OFS_MODE_STATUS, 8'hFF);
        rd(OFS_MODE_STATUS, 32'h01);
        // high-speed sleep, blocked requests, then wake
        halt(8'h04);
        chk({31'h0, cpu_halt}, 32'h1);
        chk({29'h0, sys_osc, sub_osc, tick}, 32'h7);
        rd(OFS_MODE_STATUS, 32'h04);
        u_cpu.set_lines(1'b1, 4'hF, 4'hF);
        step(6);
        chk({24'h0, mode_state}, 32'h04);
        u_cpu.set_lines(1'b0, 4'h0, 4'hF);
        step(6);
        chk({24'h0, mode_state}, 32'h04);
        u_cpu.set_lines(1'b0, 4'hF, 4'h0);
        wake(2, 0, 8'h01);
        // medium-speed sleep at ratio 16, slow wake
        wr(OFS_CONTROL_TWO, 8'h01);
        wr(OFS_CONTROL_ONE, 8'h10);
        halt(8'h08);
        ticks = 0;
        repeat (64) begin
            step(1);
            ticks += int'(tick);
        end
        chk(ticks, 32'd4);
        wake(0, 3, 8'h02);
        // pin reset ends sleep
        halt(8'h08);
        @(posedge clk);
        pin_n <= 1'b0;
        step(6);
        chk({23'h0, cpu_reset, mode_state}, 32'h101);
        pin_n <= 1'b1;
        step(5);
        chk({31'h0, cpu_reset}, 32'h0);
        // standby on the on-chip oscillator
        wr(OFS_CONTROL_TWO, 8'h00);
        wr(OFS_CLOCK_SRC, 8'h01);
        wr(OFS_CONTROL_ONE, 8'h01);
        halt(8'h10);
        chk({30'h0, port_hiz, wdt_run}, 32'h3);
        chk({29'h0, sys_osc, ser_rst, aon_run}, 32'h3);
        wake(1, 0, 8'h01);
        // watch with the watchdog on watch clock by 256, clock unit off
        wr(OFS_CLOCK_SRC, 8'h04);
        wr(OFS_CONTROL_ONE, 8'h05);
        halt(8'h20);
        chk({30'h0, wdt_run, rtc_run}, 32'h2);
        chk({28'h0, tick, twi_run, ser_rst, port_hiz}, 32'h2);
        wake(3, 0, 8'h01);
        // direct transition to subactive, then subsleep and back
        wr(OFS_CLOCK_SRC, 8'h08);
        wr(OFS_CONTROL_TWO, 8'h02);
        wr(OFS_CONTROL_ONE, 8'h07);
        halt(8'h40);
        chk({30'h0, sys_osc, rtc_run}, 32'h1);
        wr(OFS_CONTROL_ONE, 8'h06);
        halt(8'h80);
        chk({30'h0, cpu_halt, wdt_run}, 32'h2);
        wake(0, 0, 8'h40);
        give_verdict();
    end
endmodule
